// ---- core/pin_input_qualifier_and_mux.sv ----
// Top of the pin input qualifier and peripheral input multiplexer.
// Assumes an APB master on pclk and asynchronous pin inputs.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "pin_qual_params.svh"

// Notes on behaviour
// - Period zero: sample every clock
// - Period n: sample every 2n clocks
// - Eight pins share one period field
// - Select code 10 picks six samples
// - Six-sample window spans five periods
// - Short glitches never change qualified input in three/six-sample modes
// - Two-bit selector: I/O or three functions
// - 00 I/O; 01,10,11 functions; pin eight 17:16
// - Reserved selector never used; pin undefined
// - Missing peripheral makes its code reserved
// - Peripheral input may come from alternative pins
// - Zero or several sources force default
// - Defaults one, except sync and transmit-enable
// - Change passes after three/six agreeing samples
// - Three-sample window spans two periods
// - Reset: plain synchronisation on every pin
module pin_input_qualifier_and_mux #(
    parameter logic [`PQ_NUM_PERIPH-1:0] PERIPH_PRESENT = {`PQ_NUM_PERIPH{1'b1}}
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`PQ_NUM_PINS-1:0] pin_in,
    output logic [`PQ_NUM_PINS-1:0] pin_data_in,
    output logic [`PQ_NUM_PERIPH-1:0] periph_in
);

    // Peripheral input indices:
    // 0-5 trip_zone_inputs 1-6, 6 pwm_sync_input, 7 capture_input,
    // 8 capture_unit_two, 9 encoder_phase_input A, 10 encoder phase B,
    // 11 encoder_strobe_input, 12 encoder_index_input,
    // 13 serial_in_from_master, 14 serial_out_to_master, 15 serial_clock_input,
    // 16 serial_transmit_enable_input, 17 uart_receive_input A, 18 uart B,
    // 19 can_receive_input A, 20 can B.
    // Route entry: {valid, code[1:0], pin[4:0]}
    localparam logic [7:0] ROUTE [0:`PQ_NUM_PERIPH-1][0:`PQ_NUM_ROUTE-1] = '{
        '{8'hAC, 8'h00, 8'h00, 8'h00},
        '{8'hAD, 8'h00, 8'h00, 8'h00},
        '{8'hAE, 8'h00, 8'h00, 8'h00},
        '{8'hAF, 8'h00, 8'h00, 8'h00},
        '{8'hF0, 8'h00, 8'h00, 8'h00},
        '{8'hF1, 8'h00, 8'h00, 8'h00},
        '{8'hC6, 8'h00, 8'h00, 8'h00},
        '{8'hE5, 8'hB8, 8'h00, 8'h00},
        '{8'hE7, 8'hB9, 8'h00, 8'h00},
        '{8'hB4, 8'h00, 8'h00, 8'h00},
        '{8'hB5, 8'h00, 8'h00, 8'h00},
        '{8'hB6, 8'h00, 8'h00, 8'h00},
        '{8'hB7, 8'h00, 8'h00, 8'h00},
        '{8'hB0, 8'h00, 8'h00, 8'h00},
        '{8'hB1, 8'h00, 8'h00, 8'h00},
        '{8'hB2, 8'h00, 8'h00, 8'h00},
        '{8'hB3, 8'h00, 8'h00, 8'h00},
        '{8'hBC, 8'h00, 8'h00, 8'h00},
        '{8'hCB, 8'hCF, 8'hD3, 8'hF7},
        '{8'hF2, 8'hBE, 8'h00, 8'h00},
        '{8'hCA, 8'hCD, 8'hD1, 8'hF5}
    };

    // Forced level of each peripheral input, one bit per index
    localparam logic [`PQ_NUM_PERIPH-1:0] PERIPH_DEFAULT = `PQ_PERIPH_DEFAULT;

    // Configuration registers
    logic [31:0] period_reg; // qual_period_control: four 8-bit fields
    logic [31:0] period_next;
    logic [31:0] qsel_lo_reg; // qual_sample_select, pins 0-15
    logic [31:0] qsel_lo_next;
    logic [31:0] qsel_hi_reg; // qual_sample_select, pins 16-31
    logic [31:0] qsel_hi_next;
    logic [31:0] mux_lo_reg; // port_a_func_select_low
    logic [31:0] mux_lo_next;
    logic [31:0] mux_hi_reg; // port_a_func_select_high
    logic [31:0] mux_hi_next;

    // APB answer registers
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;

    // Routed peripheral inputs
    logic [`PQ_NUM_PERIPH-1:0] periph_reg;
    logic [`PQ_NUM_PERIPH-1:0] periph_next;

    // Datapath nets
    logic [`PQ_NUM_GROUPS-1:0] group_strobe; // Sampling strobe per group
    logic [`PQ_NUM_PINS-1:0] qual_pin; // Qualified pin levels
    logic [1:0] func_sel [0:`PQ_NUM_PINS-1]; // Function selector per pin
    logic [1:0] qual_sel [0:`PQ_NUM_PINS-1]; // Qualification choice per pin
    logic access_done; // Access phase completes this edge
    logic addr_hit; // Address maps to a register
    logic [31:0] wr_mask; // Byte-lane write mask

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign periph_in = periph_reg;
    assign pin_data_in = qual_pin;

    // One divider per group of eight pins
    genvar g;
    generate
        for (g = 0; g < `PQ_NUM_GROUPS; g++) begin : gen_group
            qual_period_divider u_div (
                .pclk(pclk),
                .presetn(presetn),
                .period(period_reg[g*`PQ_PERIOD_W +: `PQ_PERIOD_W]),
                .strobe(group_strobe[g])
            );
        end
    endgenerate

    // Per-pin selector fields, synchroniser and qualifier
    genvar i;
    generate
        for (i = 0; i < `PQ_NUM_PINS; i++) begin : gen_pin
            if (i < 16) begin : gen_lo
                // Two bits per pin; pin eight sits at 17:16
                assign func_sel[i] = mux_lo_reg[2*i +: 2];
                assign qual_sel[i] = qsel_lo_reg[2*i +: 2];
            end else begin : gen_hi
                assign func_sel[i] = mux_hi_reg[2*(i-16) +: 2];
                assign qual_sel[i] = qsel_hi_reg[2*(i-16) +: 2];
            end
            pin_qualifier u_qual (
                .pclk(pclk),
                .presetn(presetn),
                .pin_raw(pin_in[i]),
                .sample_strobe(group_strobe[i / `PQ_GROUP_SIZE]), // Group-shared period
                .mode(pin_qual_pkg::qual_mode_e'(qual_sel[i])),
                .qualified(qual_pin[i])
            );
        end
    endgenerate

    // Peripheral input routing: exactly one source, else forced default
    genvar p;
    generate
        for (p = 0; p < `PQ_NUM_PERIPH; p++) begin : gen_periph
            always_comb begin
                logic [2:0] hits;
                logic level;
                hits = '0;
                level = 1'b0;
                for (int r = 0; r < `PQ_NUM_ROUTE; r++) begin
                    // Absent peripheral: its code acts as reserved
                    if (ROUTE[p][r][7] && PERIPH_PRESENT[p] &&
                        func_sel[ROUTE[p][r][4:0]] == ROUTE[p][r][6:5]) begin
                        // Alternative source pins
                        hits = hits + 3'h1;
                        level = qual_pin[ROUTE[p][r][4:0]];
                    end
                end
                if (hits == 3'h1) begin
                    periph_next[p] = level;
                end else begin
                    // Zero or several sources force the default
                    periph_next[p] = PERIPH_DEFAULT[p];
                end
            end
        end
    endgenerate

    // Register the routed peripheral inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_reg <= `PQ_PERIPH_DEFAULT;
        end else begin
            periph_reg <= periph_next;
        end
    end

    // Decode helpers for the APB slave
    assign access_done = psel && penable && pready_reg;
    assign wr_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Address decode
    always_comb begin
        case (paddr)
            `PQ_OFF_PERIOD,
            `PQ_OFF_QSEL_LO,
            `PQ_OFF_QSEL_HI,
            `PQ_OFF_MUX_LO,
            `PQ_OFF_MUX_HI,
            `PQ_OFF_PIN_DATA: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Next APB answer: one wait state, data and error valid with pready
    always_comb begin
        pready_next = psel && penable && !pready_reg;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (psel && penable && !pready_reg) begin
            pslverr_next = !addr_hit;
            prdata_next = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `PQ_OFF_PERIOD: begin
                        prdata_next = period_reg;
                    end
                    `PQ_OFF_QSEL_LO: begin
                        prdata_next = qsel_lo_reg;
                    end
                    `PQ_OFF_QSEL_HI: begin
                        prdata_next = qsel_hi_reg;
                    end
                    `PQ_OFF_MUX_LO: begin
                        prdata_next = mux_lo_reg;
                    end
                    `PQ_OFF_MUX_HI: begin
                        prdata_next = mux_hi_reg;
                    end
                    `PQ_OFF_PIN_DATA: begin
                        prdata_next = qual_pin;
                    end
                    default: begin
                        prdata_next = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Next configuration values on a completed write
    always_comb begin
        period_next = period_reg;
        qsel_lo_next = qsel_lo_reg;
        qsel_hi_next = qsel_hi_reg;
        mux_lo_next = mux_lo_reg;
        mux_hi_next = mux_hi_reg;
        if (access_done && pwrite) begin
            case (paddr)
                `PQ_OFF_PERIOD: begin
                    period_next = (period_reg & ~wr_mask) | (pwdata & wr_mask);
                end
                `PQ_OFF_QSEL_LO: begin
                    qsel_lo_next = (qsel_lo_reg & ~wr_mask) | (pwdata & wr_mask);
                end
                `PQ_OFF_QSEL_HI: begin
                    qsel_hi_next = (qsel_hi_reg & ~wr_mask) | (pwdata & wr_mask);
                end
                `PQ_OFF_MUX_LO: begin
                    // Reserved codes are stored as written; software avoids them
                    mux_lo_next = (mux_lo_reg & ~wr_mask) | (pwdata & wr_mask);
                end
                `PQ_OFF_MUX_HI: begin
                    mux_hi_next = (mux_hi_reg & ~wr_mask) | (pwdata & wr_mask);
                end
                default: begin
                    // Read-only or unmapped: no effect
                    period_next = period_reg;
                end
            endcase
        end
    end

    // Register configuration and APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_reg <= `PQ_RST_PERIOD;
            qsel_lo_reg <= `PQ_RST_QSEL; // Plain synchronisation after reset
            qsel_hi_reg <= `PQ_RST_QSEL;
            mux_lo_reg <= `PQ_RST_MUX;
            mux_hi_reg <= `PQ_RST_MUX;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            period_reg <= period_next;
            qsel_lo_reg <= qsel_lo_next;
            qsel_hi_reg <= qsel_hi_next;
            mux_lo_reg <= mux_lo_next;
            mux_hi_reg <= mux_hi_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

endmodule

// ---- core/pin_qual_params.svh ----
// Constants of the pin input qualifier and function multiplexer.
// Assumes inclusion by bare name from core design and testbench files.
`ifndef PIN_QUAL_PARAMS_SVH
`define PIN_QUAL_PARAMS_SVH

// Pin count and group size
`define PQ_NUM_PINS 32
`define PQ_GROUP_SIZE 8
`define PQ_NUM_GROUPS 4
`define PQ_PERIOD_W 8
`define PQ_NUM_PERIPH 21
`define PQ_NUM_ROUTE 4

// Register byte offsets on the APB
`define PQ_OFF_PERIOD 12'h000
`define PQ_OFF_QSEL_LO 12'h004
`define PQ_OFF_QSEL_HI 12'h008
`define PQ_OFF_MUX_LO 12'h00C
`define PQ_OFF_MUX_HI 12'h010
`define PQ_OFF_PIN_DATA 12'h014

// Reset values: plain synchronisation, all pins plain I/O
`define PQ_RST_PERIOD 32'h0000_0000
`define PQ_RST_QSEL 32'h0000_0000
`define PQ_RST_MUX 32'h0000_0000

// Forced level of each peripheral input when not routed from exactly one pin
`define PQ_PERIPH_DEFAULT 21'h1E_FFBF

// History depth of the sampling window
`define PQ_HIST_DEPTH 6

`endif

// ---- core/pin_qual_pkg.sv ----
// Types shared by the pin qualifier and function multiplexer.
// Assumes nothing of its surroundings.
package pin_qual_pkg;

    // Per-pin qualification choice
    typedef enum logic [1:0] {
        QUAL_SYNC  = 2'b00,
        QUAL_THREE = 2'b01,
        QUAL_SIX   = 2'b10,
        QUAL_ASYNC = 2'b11
    } qual_mode_e;

    // Per-pin function choice
    typedef enum logic [1:0] {
        FUNC_GPIO  = 2'b00,
        FUNC_PERI1 = 2'b01,
        FUNC_PERI2 = 2'b10,
        FUNC_PERI3 = 2'b11
    } func_sel_e;

endpackage

// ---- core/pin_qualifier.sv ----
// Synchroniser and sampling-window qualifier for one pin.
// Assumes the strobe comes from the group divider on the same clock.
`timescale 1ns/1ps
`include "pin_qual_params.svh"

module pin_qualifier (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_raw,
    input wire logic sample_strobe,
    input wire pin_qual_pkg::qual_mode_e mode,
    output logic qualified
);

    logic sync1_reg; // First synchroniser stage, read only by the second
    logic sync2_reg; // Synchronised pin level
    logic [`PQ_HIST_DEPTH-1:0] hist_reg; // Recent samples, newest in bit 0
    logic [`PQ_HIST_DEPTH-1:0] hist_next;
    logic q_reg; // Qualified level
    logic q_next;

    assign qualified = q_reg;

    // Next history and qualified level
    always_comb begin
        hist_next = hist_reg;
        if (sample_strobe) begin
            hist_next = {hist_reg[`PQ_HIST_DEPTH-2:0], sync2_reg};
        end
        q_next = q_reg; // Hold between qualifying events
        case (mode)
            pin_qual_pkg::QUAL_THREE: begin
                // Three agreeing samples, two periods wide
                if (&hist_reg[2:0]) begin
                    q_next = 1'b1;
                end else if (~|hist_reg[2:0]) begin
                    q_next = 1'b0;
                end
            end
            pin_qual_pkg::QUAL_SIX: begin
                // Six agreeing samples, five periods wide
                if (&hist_reg) begin
                    q_next = 1'b1;
                end else if (~|hist_reg) begin
                    q_next = 1'b0;
                end
            end
            default: begin
                // Synchronise only; async choice falls back to this
                q_next = sync2_reg;
            end
        endcase
    end

    // Register synchroniser, history and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            hist_reg <= '0;
            q_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            hist_reg <= hist_next;
            q_reg <= q_next;
        end
    end

endmodule

// ---- core/qual_period_divider.sv ----
// Free-running divider producing the sampling strobe of one pin group.
// Assumes the period value comes from a register on the same clock.
`timescale 1ns/1ps
`include "pin_qual_params.svh"

module qual_period_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`PQ_PERIOD_W-1:0] period,
    output logic strobe
);

    logic [`PQ_PERIOD_W:0] count_reg; // Cycle counter
    logic [`PQ_PERIOD_W:0] count_next;
    logic strobe_reg; // Registered strobe
    logic strobe_next;
    logic [`PQ_PERIOD_W:0] last_count; // Terminal count, 2n-1

    assign last_count = {period, 1'b0} - {{`PQ_PERIOD_W{1'b0}}, 1'b1};
    assign strobe = strobe_reg;

    // Next counter and strobe
    always_comb begin
        if (period == '0) begin
            // Sample every cycle
            count_next = '0;
            strobe_next = 1'b1;
        end else if (count_reg >= last_count) begin
            // Wrap after 2n cycles
            count_next = '0;
            strobe_next = 1'b1;
        end else begin
            count_next = count_reg + {{`PQ_PERIOD_W{1'b0}}, 1'b1};
            strobe_next = 1'b0;
        end
    end

    // Register counter and strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            strobe_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            strobe_reg <= strobe_next;
        end
    end

endmodule

// ---- testbench/pin_drive_model.sv ----
// Behavioural driver of the external pin levels.
// Assumes callers enter its task right after a rising edge of pclk.
`timescale 1ns/1ps
module pin_drive_model (
    input wire logic pclk,
    output logic [31:0] pin_in
);
    // Pins start low and stay driven
    initial pin_in = 32'h0000_0000;
    // Set one pin, then hold it w cycles; a level meant to be seen is held past its pin's qualification window
    task automatic drive(input int i, input logic v, input int w);
        pin_in[i] <= v;
        repeat (w) @(posedge pclk);
    endtask
endmodule

// ---- testbench/pin_mux_checker_assertions.sv ----
// Checker of the pin qualifier and multiplexer top, bound to its ports.
// Assumes pclk with asynchronous active-low presetn.
`timescale 1ns/1ps
`include "pin_qual_params.svh"
module pin_mux_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`PQ_NUM_PINS-1:0] pin_in,
    input wire logic [`PQ_NUM_PINS-1:0] pin_data_in,
    input wire logic [`PQ_NUM_PERIPH-1:0] periph_in
);
    logic [2:0] up_reg; // Edges since reset, saturating
    logic [2:0] up_next;
    logic mux_wr_reg; // Some selector word was written
    logic mux_wr_next;
    logic qsel_wr_reg; // Some qualification word was written
    logic qsel_wr_next;
    logic acc; // Write access seen
    // Next values of the helper state
    always_comb begin
        acc = psel && penable && pwrite;
        up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
        mux_wr_next = mux_wr_reg | (acc && (paddr == `PQ_OFF_MUX_LO || paddr == `PQ_OFF_MUX_HI));
        qsel_wr_next = qsel_wr_reg | (acc && (paddr == `PQ_OFF_QSEL_LO || paddr == `PQ_OFF_QSEL_HI));
    end
    // Helper registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_reg <= 3'h0;
            mux_wr_reg <= 1'b0;
            qsel_wr_reg <= 1'b0;
        end else begin
            up_reg <= up_next;
            mux_wr_reg <= mux_wr_next;
            qsel_wr_reg <= qsel_wr_next;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access waiting for its answer
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // One-cycle answer
    sequence s_done;
        pready ##1 !pready;
    endsequence
    chk_ready_after_wait: assert property (s_wait |=> s_done)
        else $error("pready not a single pulse after access");
    chk_ready_needs_access: assert property (!(psel && penable) |=> !pready)
        else $error("pready without access");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (psel && penable && !pready && paddr > 12'h014 |=> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (psel && penable && !pready && paddr <= 12'h014 && paddr[1:0] == 2'b00
        |=> !pslverr)
        else $error("mapped access refused");
    chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read data not zero");
    chk_default_inputs: assert property (!mux_wr_reg |-> periph_in == `PQ_PERIPH_DEFAULT)
        else $error("unrouted peripheral input not at default");
    chk_sync_follow: assert property (up_reg == 3'h7 && !qsel_wr_reg |-> pin_data_in == $past(pin_in, 3))
        else $error("plain synchronisation latency wrong");
endmodule
bind pin_input_qualifier_and_mux pin_mux_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_data_in(pin_data_in), .periph_in(periph_in));

// ---- testbench/testbench.sv ----
// Self-checking bench of the pin qualifier and multiplexer.
// Assumes the design files and the pin model are compiled first.
`timescale 1ns/1ps
`include "pin_qual_params.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sn;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd, pin_in, pin_data_in;
    logic [20:0] periph_in;
    int n_errors, n_tests;
    // Pulse table: pin, width in cycles, whether it must pass
    int p_idx [8] = '{1, 0, 0, 8, 9, 9, 16, 16};
    int p_w [8] = '{1, 3, 2, 3, 9, 13, 11, 19};
    logic p_exp [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    // Capture-two input marked absent
    pin_input_qualifier_and_mux #(.PERIPH_PRESENT(21'h1F_FEFF)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_data_in(pin_data_in),
        .periph_in(periph_in));
    pin_drive_model pins_u (.pclk(pclk), .pin_in(pin_in));
    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read and compare
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
        chk(rd, exp);
    endtask
    // Flip a pin for w cycles and watch whether the qualified level moves
    task automatic pulse(input int i, input int w, output logic seen);
        logic s;
        s = pin_data_in[i];
        seen = 1'b0;
        fork
            begin
                pins_u.drive(i, ~s, w);
                pins_u.drive(i, s, 0);
            end
            repeat (w + 40) begin
                @(posedge pclk);
                if (pin_data_in[i] !== s) seen = 1'b1;
            end
        join
    endtask
    // Verdict and end of run
    task automatic results();
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        #50000;
        n_errors++;
        results();
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        n_errors = 0;
        n_tests = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then an unmapped word
        for (int a = 0; a < 6; a++) rdchk(12'(a * 4), 32'h0000_0000);
        apb(1'b0, 12'h018, 32'h0000_0000, 4'hF);
        chk(32'(er), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        chk(32'(periph_in), 32'(`PQ_PERIPH_DEFAULT));
        chk(32'(periph_in[16]), 32'h0000_0000);
        chk(32'(periph_in[6]), 32'h0000_0000);
        // Plain synchronisation carries a pin level three edges on
        pins_u.drive(3, 1'b1, 4);
        chk(32'(pin_data_in[3]), 32'h0000_0001);
        pins_u.drive(3, 1'b0, 4);
        chk(32'(pin_data_in[3]), 32'h0000_0000);
        // Periods 0, 1, 3 for groups 0..2; top lane masked off
        apb(1'b1, `PQ_OFF_PERIOD, 32'hFF03_0100, 4'b0111);
        rdchk(`PQ_OFF_PERIOD, 32'h0003_0100);
        // Pins 0, 8, 16 three samples; pin 9 six samples; pin 6 code 11 acts as sync only
        apb(1'b1, `PQ_OFF_QSEL_LO, 32'h0009_3001, 4'hF);
        apb(1'b1, `PQ_OFF_QSEL_HI, 32'h0000_0001, 4'hF);
        for (int k = 0; k < 8; k++) begin
            pulse(p_idx[k], p_w[k], sn);
            chk(32'(sn), 32'(p_exp[k]));
        end
        // Qualified word ignores writes
        apb(1'b1, `PQ_OFF_PIN_DATA, 32'hFFFF_FFFF, 4'hF);
        rdchk(`PQ_OFF_PIN_DATA, 32'h0000_0000);
        // Pin five sel 11, pin six sel 10, pin seven sel 11 with its input absent
        pins_u.drive(6, 1'b1, 0);
        apb(1'b1, `PQ_OFF_MUX_LO, 32'h0000_EC00, 4'hF);
        repeat (3) @(posedge pclk);
        chk(32'(periph_in[8:6]), 32'h0000_0005);
        rdchk(`PQ_OFF_PIN_DATA, 32'h0000_0040);
        // Second source for the capture input
        apb(1'b1, `PQ_OFF_MUX_HI, 32'h0001_0000, 4'hF);
        repeat (3) @(posedge pclk);
        chk(32'(periph_in[7]), 32'h0000_0001);
        // Only the alternative pin remains
        apb(1'b1, `PQ_OFF_MUX_LO, 32'h0000_0000, 4'hF);
        repeat (3) @(posedge pclk);
        chk(32'(periph_in[8:6]), 32'h0000_0004);
        pins_u.drive(24, 1'b1, 6);
        chk(32'(periph_in[7]), 32'h0000_0001);
        results();
    end
endmodule
